// [rtl/irg_device.sv]
// Identity device end: id code, check byte, command gate, program guard
// Function
// [RULE1] Hold 64-bit id: family, serial, check
// [RULE2] Serial sits after family, unique per part
// [RULE3] Top byte checks the lower 56 bits
// [RULE4] Polynomial x8 + x5 + x4 + 1
// [RULE5] Accumulator starts at zero
// [RULE6] Family LSB first, then serial bits
// [RULE7] After serial, accumulator equals check byte
// [RULE8] Shifting check byte in yields zero
// [RULE9] Memory commands refused before ROM selection
// [RULE10] Master opens with one of four ROM commands
// [RULE11] After selection accept five memory commands
// [RULE12] ROM commands single out one device
// [RULE13] Bits move least significant first
// [RULE14] Flag raised while programming voltage present
// [RULE15] Master pulses programming voltage after commands
// [RULE16] Programming only clears ones to zero
// [RULE17] 16384 data bits plus 704 status bits
// [RULE18] Sixty-four addressable pages of 256 bits
// [RULE19] Protected pages refuse further programming
// [RULE20] Xor with low bit, shift right, tap inject
`timescale 1ns/1ps
`default_nettype none
module irg_device
    import irg_pkg::*;
#(
    parameter logic [47:0] SERIAL = irg_pkg::SERIAL_DEF,
    parameter logic [7:0]  FAMILY = irg_pkg::FAMILY_DEF
) (
    // Clock and reset
    input  wire logic          CORE_CLK,
    input  wire logic          RESET,
    // Link
    irg_link_if.dev            LINK,
    // Program request from local store
    input  wire logic          PROG_REQ,
    input  wire logic [5:0]    PROG_PAGE,
    input  wire logic [7:0]    PROG_OLD,
    input  wire logic [7:0]    PROG_NEW,
    input  wire logic          PAGE_LOCK,
    // Status
    output logic [7:0]         PROG_RESULT,
    output logic               PROG_DONE,
    output logic               PROG_FLAG,
    output logic               ID_CHECK_OK,
    output logic [63:0]        ID_CODE
);
    import irg_pkg::*;

    logic [7:0]       crc_ff;
    logic [CNT_W-1:0] idx_ff;
    logic             busy_ff;
    logic             sel_ff;
    logic             done_ff;
    logic             ok_ff;
    logic             pv_s1_ff;
    logic             pv_s2_ff;
    logic [7:0]       res_ff;
    logic             pdone_ff;
    logic             bv_ff;
    logic             bd_ff;
    logic             ref_ff;
    logic             mok_ff;

    wire [55:0] id_body = {SERIAL, FAMILY};                // RULE1 RULE2
    // Check byte worked out at elaboration with the same step as the link
    function automatic logic [7:0] body_crc(input logic [55:0] b);
        logic [7:0] c;
        c = CRC_INIT;                                       // RULE5
        for (int i = 0; i < BODY_W; i++) begin
            c = irg_crc_step(c, b[i]);                      // RULE6 RULE20
        end
        body_crc = c;                                       // RULE7
    endfunction
    wire [7:0]  id_crc  = body_crc(id_body);               // RULE3 RULE4
    wire [63:0] id_full = {id_crc, id_body};
    assign ID_CODE = id_full;

    wire cur_bit   = id_full[idx_ff[5:0]];                 // RULE13
    wire [7:0] nxt_crc = irg_crc_step(crc_ff, cur_bit);
    wire last_bit  = (idx_ff == BIT_LAST);
    wire is_match  = (LINK.rom_cmd == IRG_ROM_MATCH);
    wire is_read   = (LINK.rom_cmd == IRG_ROM_READ) ||
                     (LINK.rom_cmd == IRG_ROM_SEARCH);
    // Match selects only when the master code equals ours
    wire rom_sel   = is_match ? (LINK.match_id == id_full) : 1'b1; // RULE12
    wire mem_take  = LINK.mem_valid && sel_ff;              // RULE9 RULE11
    wire mem_block = LINK.mem_valid && !sel_ff;             // RULE9
    // Programming only ever clears bits; locked pages keep the old byte
    // Arrays live outside; the page index must name one of the pages
    wire page_in_range = ({1'b0, PROG_PAGE} < 7'(PAGES));   // RULE17 RULE18
    wire prog_ok   = PROG_REQ && pv_s2_ff && !PAGE_LOCK &&
                     page_in_range;                         // RULE14 RULE19
    wire [7:0] prog_val = prog_ok ? (PROG_OLD & PROG_NEW) : PROG_OLD; // RULE16

    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            crc_ff  <= CRC_INIT;
            idx_ff  <= '0;
            busy_ff <= 1'b0;
            sel_ff  <= 1'b0;
            done_ff <= 1'b0;
            ok_ff   <= 1'b0;
            bv_ff   <= 1'b0;
            bd_ff   <= 1'b0;
        end else begin
            done_ff <= 1'b0;
            bv_ff   <= 1'b0;
            if (LINK.rom_valid && !busy_ff) begin
                sel_ff  <= rom_sel;
                done_ff <= !is_read;
                busy_ff <= is_read || LINK.id_req;
                idx_ff  <= '0;
                crc_ff  <= CRC_INIT;                        // RULE5
            end else if (busy_ff) begin
                bv_ff   <= 1'b1;
                bd_ff   <= cur_bit;                         // RULE13
                crc_ff  <= nxt_crc;                         // RULE20
                idx_ff  <= idx_ff + 7'h01;
                if (last_bit) begin
                    busy_ff <= 1'b0;
                    done_ff <= 1'b1;
                    ok_ff   <= (nxt_crc == CRC_INIT);       // RULE8
                end
            end
        end
    end

    // Programming voltage detect is asynchronous, so it is synchronised
    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            pv_s1_ff <= 1'b0;
            pv_s2_ff <= 1'b0;
            res_ff   <= '0;
            pdone_ff <= 1'b0;
            ref_ff   <= 1'b0;
            mok_ff   <= 1'b0;
        end else begin
            pv_s1_ff <= LINK.prog_v;
            pv_s2_ff <= pv_s1_ff;                           // RULE14
            pdone_ff <= PROG_REQ;
            if (PROG_REQ) begin
                res_ff <= prog_val;                         // RULE16
            end
            ref_ff <= mem_block;                            // RULE9
            mok_ff <= mem_take;                             // RULE11
        end
    end

    assign LINK.bit_valid   = bv_ff;
    assign LINK.bit_data    = bd_ff;
    assign LINK.rom_done    = done_ff;
    assign LINK.selected    = sel_ff;
    assign LINK.mem_ok      = mok_ff;
    assign LINK.mem_refused = ref_ff;
    assign PROG_RESULT = res_ff;
    assign PROG_DONE   = pdone_ff;
    assign PROG_FLAG   = pv_s2_ff;
    assign ID_CHECK_OK = ok_ff;
endmodule
`default_nettype wire

// [rtl/irg_pkg.sv]
// Package of constants and types shared by both ends of the identity gate
package irg_pkg;
    localparam int ID_W      = 64;
    localparam int FAM_W     = 8;
    localparam int SER_W     = 48;
    localparam int CRC_W     = 8;
    localparam int BODY_W    = FAM_W + SER_W;
    localparam int FAM_LSB   = 0;
    localparam int SER_LSB   = FAM_LSB + FAM_W;
    localparam int CRC_LSB   = SER_LSB + SER_W;
    localparam logic [7:0] CRC_POLY_REV = 8'h8c;
    localparam logic [7:0] CRC_INIT     = 8'h00;
    localparam int CNT_W     = 7;
    localparam logic [CNT_W-1:0] BIT_LAST = 7'h3f;
    localparam logic [CNT_W-1:0] BODY_LAST = 7'h37;
    // Family code value is arbitrary
    localparam logic [7:0] FAMILY_DEF = 8'h5a;
    localparam logic [47:0] SERIAL_DEF = 48'h0123_4567_89ab;
    localparam int DATA_BITS   = 16384;
    localparam int STAT_BITS   = 704;
    localparam int PAGE_BITS   = 256;
    localparam int PAGES       = DATA_BITS / PAGE_BITS;
    localparam int PAGE_W      = 6;
    localparam int MEM_CMDS    = 5;
    typedef enum logic [1:0] {
        IRG_ROM_READ, IRG_ROM_MATCH, IRG_ROM_SEARCH, IRG_ROM_SKIP
    } irg_rom_cmd_t;
    typedef enum logic [2:0] {
        IRG_MEM_READ, IRG_MEM_READ_STAT, IRG_MEM_WRITE,
        IRG_MEM_WRITE_STAT, IRG_MEM_READ_CRC
    } irg_mem_cmd_t;
    // Serial check step, LSB first
    function automatic logic [7:0] irg_crc_step(input logic [7:0] c,
                                                 input logic b);
        logic fb;
        fb = c[0] ^ b;
        irg_crc_step = (c >> 1) ^ (fb ? CRC_POLY_REV : 8'h00);
    endfunction
endpackage

// [rtl/irg_link_if.sv]
// Interface joining the bus master end and the identity device end
`timescale 1ns/1ps
`default_nettype none
interface irg_link_if;
    logic                 rom_valid;
    irg_pkg::irg_rom_cmd_t rom_cmd;
    logic [63:0]          match_id;
    logic                 mem_valid;
    irg_pkg::irg_mem_cmd_t mem_cmd;
    logic                 id_req;
    logic                 bit_valid;
    logic                 bit_data;
    logic                 mem_ok;
    logic                 mem_refused;
    logic                 rom_done;
    logic                 selected;
    logic                 prog_v;
    modport dev  (input rom_valid, rom_cmd, match_id, mem_valid, mem_cmd,
                  id_req, prog_v,
                  output bit_valid, bit_data, mem_ok, mem_refused,
                  rom_done, selected);
    modport host (output rom_valid, rom_cmd, match_id, mem_valid, mem_cmd,
                  id_req, prog_v,
                  input bit_valid, bit_data, mem_ok, mem_refused,
                  rom_done, selected);
endinterface
`default_nettype wire

// [rtl/irg_master.sv]
// Bus master end: issues ROM and memory commands, checks the id stream
`timescale 1ns/1ps
`default_nettype none
module irg_master
    import irg_pkg::*;
(
    // Clock and reset
    input  wire logic           CORE_CLK,
    input  wire logic           RESET,
    // Link
    irg_link_if.host            LINK,
    // User side
    input  wire logic           ROM_START,
    input  wire irg_pkg::irg_rom_cmd_t ROM_CMD,
    input  wire logic [63:0]    MATCH_ID,
    input  wire logic           MEM_START,
    input  wire irg_pkg::irg_mem_cmd_t MEM_CMD,
    input  wire logic           PROG_PULSE,
    output logic [63:0]         RX_ID,
    output logic                RX_DONE,
    output logic                RX_CRC_OK,
    output logic                BODY_CRC_OK
);
    import irg_pkg::*;

    logic [7:0]       crc_ff;
    logic [7:0]       bcrc_ff;
    logic [CNT_W-1:0] idx_ff;
    logic [63:0]      id_ff;
    logic             done_ff;
    logic             ok_ff;
    logic             bok_ff;
    logic             rom_seen_ff;

    wire [7:0] nxt_crc   = irg_crc_step(crc_ff, LINK.bit_data); // RULE4 RULE20
    wire       last_bit  = (idx_ff == BIT_LAST);
    wire       body_last = (idx_ff == BODY_LAST);
    // A memory command is only sent after a ROM command opened the exchange
    wire       rom_go    = ROM_START;                           // RULE10

    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            crc_ff      <= CRC_INIT;
            bcrc_ff     <= CRC_INIT;
            idx_ff      <= '0;
            id_ff       <= '0;
            done_ff     <= 1'b0;
            ok_ff       <= 1'b0;
            bok_ff      <= 1'b0;
            rom_seen_ff <= 1'b0;
        end else begin
            done_ff <= 1'b0;
            if (rom_go) begin
                crc_ff      <= CRC_INIT;                        // RULE5
                idx_ff      <= '0;
                rom_seen_ff <= 1'b1;
            end else if (LINK.bit_valid) begin
                id_ff  <= {LINK.bit_data, id_ff[63:1]};         // RULE13
                crc_ff <= nxt_crc;                              // RULE6
                idx_ff <= idx_ff + 7'h01;
                // Check byte has not arrived yet, so keep the body value
                if (body_last) begin
                    bcrc_ff <= nxt_crc;                         // RULE7
                end
                if (last_bit) begin
                    bok_ff  <= (bcrc_ff == {LINK.bit_data, id_ff[63:57]}); // RULE7
                    done_ff <= 1'b1;
                    ok_ff   <= (nxt_crc == CRC_INIT);           // RULE8
                end
            end
        end
    end

    assign LINK.rom_valid = rom_go;
    assign LINK.rom_cmd   = ROM_CMD;
    assign LINK.match_id  = MATCH_ID;
    assign LINK.id_req    = 1'b0;
    assign LINK.mem_valid = MEM_START && rom_seen_ff;           // RULE10
    assign LINK.mem_cmd   = MEM_CMD;
    assign LINK.prog_v    = PROG_PULSE;                         // RULE15
    assign RX_ID       = id_ff;
    assign RX_DONE     = done_ff;
    assign RX_CRC_OK   = ok_ff;
    assign BODY_CRC_OK = bok_ff;
endmodule
`default_nettype wire

// [testbench/irg_link_checker.sv]
// Checker of link handshakes between master and identity device
`timescale 1ns/1ps
`default_nettype none
module irg_link_checker
    import irg_pkg::*;
(
    // Clock and reset
    input wire logic                 CORE_CLK,
    input wire logic                 RESET,
    // Link
    input wire logic                 rom_valid,
    input wire irg_pkg::irg_rom_cmd_t rom_cmd,
    input wire logic                 mem_valid,
    input wire logic                 bit_valid,
    input wire logic                 mem_ok,
    input wire logic                 mem_refused,
    input wire logic                 rom_done,
    input wire logic                 selected
);
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RESET);
    a_refuse_unselected: assert property (
        mem_valid && !selected |=> mem_refused && !mem_ok)
        else $error("memory command answered while unselected");
    a_accept_selected: assert property (
        mem_valid && selected |=> mem_ok && !mem_refused)
        else $error("memory command not accepted while selected");
    a_answer_has_cause: assert property (
        mem_ok || mem_refused |-> $past(mem_valid))
        else $error("memory answer without a command");
    a_read_stream_start: assert property (
        rom_valid && rom_cmd == IRG_ROM_READ && !bit_valid
        |=> selected && !bit_valid ##1 bit_valid [*8])
        else $error("identity stream did not start on time");
    a_stream_length: assert property (
        $rose(bit_valid) |-> ##63 (bit_valid && rom_done) ##1 !bit_valid)
        else $error("identity stream not 64 bits long");
    a_done_single: assert property (
        rom_done |=> !rom_done)
        else $error("rom done longer than one cycle");
    a_skip_selects: assert property (
        rom_valid && rom_cmd == IRG_ROM_SKIP && !bit_valid
        |=> selected && rom_done)
        else $error("skip did not select at once");
    a_select_holds: assert property (
        selected && !rom_valid |=> selected)
        else $error("selection lost without a rom command");
    c_read: cover property (rom_valid && rom_cmd == IRG_ROM_READ);
    c_skip: cover property (rom_valid && rom_cmd == IRG_ROM_SKIP);
    c_refused: cover property (mem_refused);
    c_accepted: cover property (mem_ok);
endmodule
`default_nettype wire

// [testbench/id_rom_crc_and_access_gate_bench.sv]
// Self-checking bench joining master and identity device over the link
`timescale 1ns/1ps
`default_nettype none
module id_rom_crc_and_access_gate_bench;
    import irg_pkg::*;
    // Part values are arbitrary
    localparam logic [7:0]  FAM = 8'h3c;
    localparam logic [47:0] SER = 48'h00fe_dcba_9876;
    logic         CORE_CLK = 1'b0;
    logic         RESET = 1'b1;
    logic         ROM_START = 1'b0;
    irg_rom_cmd_t ROM_CMD = IRG_ROM_READ;
    logic [63:0]  MATCH_ID = 64'h0;
    logic         MEM_START = 1'b0;
    irg_mem_cmd_t MEM_CMD = IRG_MEM_READ;
    logic         PROG_PULSE = 1'b0, PROG_REQ = 1'b0, PAGE_LOCK = 1'b0;
    logic [5:0]   PROG_PAGE = 6'h00;
    logic [7:0]   PROG_OLD = 8'h00, PROG_NEW = 8'h00, PROG_RESULT;
    logic         PROG_DONE, PROG_FLAG, ID_CHECK_OK;
    logic         RX_DONE, RX_CRC_OK, BODY_CRC_OK;
    logic [63:0]  ID_CODE, RX_ID, cap_id, exp_id;
    int           n_mismatch = 0, checks_done = 0, b;
    int           n_done = 0, n_ok = 0, n_ref = 0, n_prog = 0;
    irg_link_if i_irg_link_if ();
    irg_device #(.SERIAL(SER), .FAMILY(FAM)) i_irg_device (
        .CORE_CLK(CORE_CLK), .RESET(RESET), .LINK(i_irg_link_if),
        .PROG_REQ(PROG_REQ), .PROG_PAGE(PROG_PAGE), .PROG_OLD(PROG_OLD),
        .PROG_NEW(PROG_NEW), .PAGE_LOCK(PAGE_LOCK),
        .PROG_RESULT(PROG_RESULT), .PROG_DONE(PROG_DONE),
        .PROG_FLAG(PROG_FLAG), .ID_CHECK_OK(ID_CHECK_OK), .ID_CODE(ID_CODE));
    irg_master i_irg_master (
        .CORE_CLK(CORE_CLK), .RESET(RESET), .LINK(i_irg_link_if),
        .ROM_START(ROM_START), .ROM_CMD(ROM_CMD), .MATCH_ID(MATCH_ID),
        .MEM_START(MEM_START), .MEM_CMD(MEM_CMD), .PROG_PULSE(PROG_PULSE),
        .RX_ID(RX_ID), .RX_DONE(RX_DONE), .RX_CRC_OK(RX_CRC_OK),
        .BODY_CRC_OK(BODY_CRC_OK));
    irg_link_checker i_irg_link_checker (
        .CORE_CLK(CORE_CLK), .RESET(RESET),
        .rom_valid(i_irg_link_if.rom_valid), .rom_cmd(i_irg_link_if.rom_cmd),
        .mem_valid(i_irg_link_if.mem_valid),
        .bit_valid(i_irg_link_if.bit_valid), .mem_ok(i_irg_link_if.mem_ok),
        .mem_refused(i_irg_link_if.mem_refused),
        .rom_done(i_irg_link_if.rom_done), .selected(i_irg_link_if.selected));
    always #4 CORE_CLK = ~CORE_CLK;
    // Wire bits land at the top so the first bit ends as bit 0
    always @(posedge CORE_CLK) begin
        if (i_irg_link_if.bit_valid)
            cap_id <= {i_irg_link_if.bit_data, cap_id[63:1]};
        if (i_irg_link_if.rom_done) n_done <= n_done + 1;
        if (i_irg_link_if.mem_ok) n_ok <= n_ok + 1;
        if (i_irg_link_if.mem_refused) n_ref <= n_ref + 1;
        if (PROG_DONE) n_prog <= n_prog + 1;
    end
    function automatic logic [7:0] crc_of(input logic [55:0] d);
        logic [7:0] c;
        logic       fb;
        c = 8'h00;
        for (int i = 0; i < 56; i++) begin
            fb = c[0] ^ d[i];
            c = {1'b0, c[7:1]} ^ (fb ? 8'h8c : 8'h00);
        end
        return c;
    endfunction
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask
    task automatic give_verdict();
        $display("Checks %0d, mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    function automatic int ev(input int s);
        case (s)
            0: return n_done;
            1: return n_ok;
            2: return n_ref;
            default: return n_prog;
        endcase
    endfunction
    // Counters settle after the edge, hence the small delay
    task automatic await(input int s, input int b0);
        for (int k = 0; k < 200 && ev(s) == b0; k++) @(posedge CORE_CLK) #1;
        if (ev(s) == b0) begin
            n_mismatch++;
            $display("Wait limit reached at %0t", $time);
            give_verdict();
        end
    endtask
    task automatic rom(input irg_rom_cmd_t c, input logic [63:0] id);
        int b0;
        b0 = n_done;
        @(negedge CORE_CLK);
        ROM_START = 1'b1;
        ROM_CMD = c;
        MATCH_ID = id;
        @(negedge CORE_CLK);
        ROM_START = 1'b0;
        await(0, b0);
        repeat (3) @(negedge CORE_CLK);
    endtask
    task automatic mem(input irg_mem_cmd_t c, input int s);
        int b0;
        b0 = ev(s);
        @(negedge CORE_CLK);
        MEM_START = 1'b1;
        MEM_CMD = c;
        @(negedge CORE_CLK);
        MEM_START = 1'b0;
        await(s, b0);
    endtask
    task automatic prog(input logic [7:0] o, n, input logic lk,
                        input logic [7:0] e);
        int b0;
        b0 = n_prog;
        @(negedge CORE_CLK);
        {PROG_REQ, PROG_OLD, PROG_NEW, PAGE_LOCK, PROG_PAGE} = {1'b1, o, n, lk, 6'h3f};
        @(negedge CORE_CLK);
        PROG_REQ = 1'b0;
        await(3, b0);
        chk({56'h0, PROG_RESULT}, {56'h0, e});
    endtask
    task automatic flag_is(input logic v);
        PROG_PULSE = v;
        for (int k = 0; k < 10 && PROG_FLAG !== v; k++) @(negedge CORE_CLK);
        chk({63'h0, PROG_FLAG}, {63'h0, v});
    endtask
    initial begin
        exp_id = {crc_of({SER, FAM}), SER, FAM};
        repeat (6) @(negedge CORE_CLK);
        RESET = 1'b0;
        b = n_ok + n_ref;
        @(negedge CORE_CLK) MEM_START = 1'b1;
        @(negedge CORE_CLK) MEM_START = 1'b0;
        repeat (6) @(negedge CORE_CLK);
        chk(64'(n_ok + n_ref), 64'(b));
        chk({63'h0, i_irg_link_if.selected}, 64'h0);
        $display("Test gate finished");
        for (int t = 0; t < 2; t++) begin
            rom(t ? IRG_ROM_SEARCH : IRG_ROM_READ, 64'h0);
            chk(cap_id, exp_id);
            chk(RX_ID, exp_id);
            chk({62'h0, RX_CRC_OK, BODY_CRC_OK}, 64'h3);
        end
        chk(ID_CODE, exp_id);
        chk({63'h0, ID_CHECK_OK}, 64'h1);
        for (int m = 0; m < MEM_CMDS; m++) mem(irg_mem_cmd_t'(m), 1);
        $display("Test identity read finished");
        rom(IRG_ROM_MATCH, ~exp_id);
        chk({63'h0, i_irg_link_if.selected}, 64'h0);
        mem(IRG_MEM_WRITE, 2);
        rom(IRG_ROM_MATCH, exp_id);
        mem(IRG_MEM_READ_CRC, 1);
        rom(IRG_ROM_SKIP, 64'h0);
        mem(IRG_MEM_WRITE_STAT, 1);
        $display("Test selection finished");
        flag_is(1'b1);
        prog(8'hf0, 8'h3c, 1'b0, 8'h30);
        prog(8'h0f, 8'hff, 1'b0, 8'h0f);
        prog(8'hff, 8'h00, 1'b1, 8'hff);
        flag_is(1'b0);
        prog(8'hff, 8'h00, 1'b0, 8'hff);
        $display("Test programming finished");
        give_verdict();
    end
endmodule
`default_nettype wire
